// >>> common/uart_defs.svh
// Register offsets, field positions, reset values and timing counts of the serial port.
`ifndef UART_DEFS_SVH
`define UART_DEFS_SVH

`define UART_ADDR_W 12
`define STA_OFFSET 12'h000
`define TXD_OFFSET 12'h004
`define RXD_OFFSET 12'h008
`define MODE_OFFSET 12'h00c
`define BAUD_OFFSET 12'h010

`define STA_AUTO_MATCH 24
`define STA_UNUSED_HI 31
`define STA_UNUSED_LO 25
`define STA_MATCH_HI 23
`define STA_MATCH_LO 16
`define STA_TXISEL_HI 15
`define STA_TXISEL_LO 14
`define STA_TXINV 13
`define STA_RXEN 12
`define STA_BRK 11
`define STA_TXEN 10
`define STA_TXBF 9
`define STA_TX_ALL_EMPTY 8
`define STA_RXISEL_HI 7
`define STA_RXISEL_LO 6
`define STA_NINE 5
`define STA_RECEIVER_IDLE 4
`define STA_PARITY_ERROR_FLAG 3
`define STA_FRAMING_ERROR_FLAG 2
`define STA_OVERRUN_FLAG 1
`define STA_RX_DATA_AVAILABLE 0

`define MODE_ON 15
`define MODE_IR 12

`define TXISEL_FREE 2'b00
`define TXISEL_DONE 2'b01
`define TXISEL_EMPTY 2'b10
`define TXISEL_RSVD 2'b11

`define BAUD_RESET 16'h0000
`define TX_DEPTH 32
`define DATA_BITS 4'h8
`define BREAK_ZEROS 4'hc
`define SUB_LAST 4'hf
`define SUB_MID 4'h7
`define IR_PULSE_TICKS 4'h3

`endif

// >>> common/uart_pkg.sv
// Types shared by the serial port status and control logic.
package uart_pkg;

  typedef struct packed {
    logic auto_match;
    logic [7:0] match;
    logic [1:0] tx_isel;
    logic tx_inv;
    logic rx_en;
    logic tx_en;
    logic [1:0] rx_isel;
    logic nine_bit;
  } ctrl_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_BITS = 2'b11,
    TX_STOP = 2'b10
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b11,
    RX_STOP = 2'b10
  } rx_state_t;

endpackage

// >>> design/tx_fifo.sv
// Flip-flop FIFO with valid and ready on both sides and a synchronous flush.
`timescale 1ns/1ns
module tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("tx_fifo depth must be a power of two of at least 2");
    end
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (cnt_q != DEPTH[AW:0]) & ~flush;
  assign out_valid = (cnt_q != '0) & ~flush;
  assign out_data = mem_q[rd_q];
  assign count = cnt_q;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_q + AW'(push);
      rd_q <= rd_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> design/uart_status_control.sv
// Serial port with its combined status and control register, reached over APB.
//
// Functional notes
// - Auto match enable bit 24 turns automatic address detection on or off.
// - In auto match mode received characters are compared against match bits 23-16.
// - Transmit select 10 raises transmit interrupt while the transmit buffer is empty.
// - Transmit select 01 raises transmit interrupt once all characters are shifted out.
// - Transmit select 00 raises transmit interrupt while the buffer has a free slot.
// - Without infrared, transmit pin idles low when invert is 1, else high.
// - With infrared, encoded transmit output idles high when invert is 1, else low.
// - Receiver enable with module on owns the receive pin; otherwise pin is ignored.
// - Break request sends start, twelve zeros, stop, then hardware clears the request.
// - Clearing transmit enable aborts, flushes the buffer and releases the transmit pin.
// - Buffer full flag reads 1 when the buffer holds TX_DEPTH characters; it reads 0 while transmit enable is clear.
// - Transmitter empty flag is 1 only with shifter and buffer empty; resets to 1.
// - Status bits 31 to 25 always read zero.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "uart_defs.svh"
module uart_status_control #(
  parameter int TX_DEPTH = `TX_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`UART_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pin_in,
  output logic rx_pin_owned,
  output logic tx_pin_out,
  output logic tx_pin_oe_n,
  output logic tx_irq,
  output logic rx_irq,
  output logic auto_match_active
);
  initial begin
    if (TX_DEPTH < 2) begin
      $error("transmit buffer depth must be at least 2");
    end
  end

  localparam int CW = $clog2(TX_DEPTH) + 1;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.

  uart_pkg::ctrl_t ctrl_q;
  logic brk_q;
  logic on_q;
  logic ir_q;
  logic [15:0] baud_q;
  logic [31:0] prdata_q;
  logic [7:0] rx_data_q;
  logic avail_q;
  logic framing_error_flag_q;
  logic overrun_flag_q;
  logic locked_q;

  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire sel_sta = paddr == `STA_OFFSET;
  wire sel_txd = paddr == `TXD_OFFSET;
  wire sel_rxd = paddr == `RXD_OFFSET;
  wire sel_mode = paddr == `MODE_OFFSET;
  wire sel_baud = paddr == `BAUD_OFFSET;
  wire hit = sel_sta | sel_txd | sel_rxd | sel_mode | sel_baud;
  wire sta_wr = wr & sel_sta;
  wire txd_wr = wr & sel_txd;
  wire rxd_rd = acc & ~pwrite & sel_rxd;

  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata = prdata_q;

  logic [CW-1:0] fifo_count;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  uart_pkg::tx_state_t tx_state_q;
  uart_pkg::rx_state_t rx_state_q;

  // Counted rather than taken from the buffer's ready, so a disabled transmitter never reads as full.
  wire tx_buffer_full = fifo_count == CW'(TX_DEPTH);
  wire tx_all_empty = (tx_state_q == uart_pkg::TX_IDLE) & ~fifo_out_valid;
  wire receiver_idle = rx_state_q == uart_pkg::RX_IDLE;

  wire [31:0] sta_rd = {7'h00, ctrl_q.auto_match, ctrl_q.match, ctrl_q.tx_isel, ctrl_q.tx_inv,
                        ctrl_q.rx_en, brk_q, ctrl_q.tx_en, tx_buffer_full, tx_all_empty,
                        ctrl_q.rx_isel, ctrl_q.nine_bit, receiver_idle, 1'b0, framing_error_flag_q, overrun_flag_q, avail_q};
  wire [31:0] rd_mux = sel_sta ? sta_rd :
                       sel_rxd ? {24'h000000, rx_data_q} :
                       sel_mode ? {16'h0000, on_q, 2'b00, ir_q, 12'h000} :
                       sel_baud ? {16'h0000, baud_q} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      on_q <= 1'b0;
      ir_q <= 1'b0;
      baud_q <= `BAUD_RESET;
    end else begin
      if (sta_wr) begin
        ctrl_q <= {pwdata[`STA_AUTO_MATCH], pwdata[`STA_MATCH_HI:`STA_MATCH_LO],
                   pwdata[`STA_TXISEL_HI:`STA_TXISEL_LO], pwdata[`STA_TXINV], pwdata[`STA_RXEN],
                   pwdata[`STA_TXEN], pwdata[`STA_RXISEL_HI:`STA_RXISEL_LO], pwdata[`STA_NINE]};
      end
      if (wr & sel_mode) begin
        on_q <= pwdata[`MODE_ON];
        ir_q <= pwdata[`MODE_IR];
      end
      if (wr & sel_baud) begin
        baud_q <= pwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud divider and transmit buffer.

  logic [15:0] div_q;
  wire tick = on_q & (div_q == baud_q);
  wire tx_run = on_q & ctrl_q.tx_en;
  wire flush = ~ctrl_q.tx_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= (tick | ~on_q) ? 16'h0000 : div_q + 16'h0001;
    end
  end

  tx_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .flush(flush),
    .in_valid(txd_wr),
    .in_ready(fifo_in_ready),
    .in_data(pwdata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .count(fifo_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter.

  logic [3:0] tx_sub_q;
  logic [3:0] tx_bit_q;
  logic [7:0] tx_shift_q;
  logic tx_is_brk_q;
  logic tx_out_q;

  wire tx_idle = tx_state_q == uart_pkg::TX_IDLE;
  wire sub_end = tick & (tx_sub_q == `SUB_LAST);
  wire start_brk = tx_run & tx_idle & tick & brk_q;
  assign fifo_out_ready = tx_run & tx_idle & tick & ~brk_q;
  wire start_chr = fifo_out_ready & fifo_out_valid;
  wire [3:0] bit_last = tx_is_brk_q ? `BREAK_ZEROS - 4'h1 : `DATA_BITS - 4'h1;
  wire brk_done = tx_is_brk_q & (tx_state_q == uart_pkg::TX_STOP) & sub_end;
  wire line_bit = (tx_state_q == uart_pkg::TX_BITS) ? tx_shift_q[0] :
                  (tx_state_q == uart_pkg::TX_START) ? 1'b0 : 1'b1;
  wire ir_level = ctrl_q.tx_inv ^ (~line_bit & ~tx_idle & (tx_sub_q < `IR_PULSE_TICKS));
  wire plain_level = line_bit ^ ctrl_q.tx_inv;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_q <= uart_pkg::TX_IDLE;
      tx_sub_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_shift_q <= 8'h00;
      tx_is_brk_q <= 1'b0;
    end else if (~tx_run) begin
      tx_state_q <= uart_pkg::TX_IDLE;
      tx_sub_q <= 4'h0;
    end else begin
      if (tick & ~tx_idle) begin
        tx_sub_q <= tx_sub_q + 4'h1;
      end
      case (tx_state_q)
        uart_pkg::TX_IDLE: begin
          if (start_brk | start_chr) begin
            tx_state_q <= uart_pkg::TX_START;
            tx_shift_q <= start_brk ? 8'h00 : fifo_out_data;
            tx_is_brk_q <= start_brk;
            tx_sub_q <= 4'h0;
          end
        end
        uart_pkg::TX_START: begin
          if (sub_end) begin
            tx_state_q <= uart_pkg::TX_BITS;
            tx_bit_q <= 4'h0;
          end
        end
        uart_pkg::TX_BITS: begin
          if (sub_end) begin
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_bit_q == bit_last) begin
              tx_state_q <= uart_pkg::TX_STOP;
            end
          end
        end
        uart_pkg::TX_STOP: begin
          if (sub_end) begin
            tx_state_q <= uart_pkg::TX_IDLE;
          end
        end
        default: tx_state_q <= uart_pkg::TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_q <= 1'b0;
      tx_out_q <= 1'b1;
    end else begin
      // A request written in the cycle the previous break completes is kept.
      brk_q <= sta_wr ? pwdata[`STA_BRK] : (brk_q & ~brk_done);
      tx_out_q <= ir_q ? ir_level : plain_level;
    end
  end

  assign tx_pin_out = tx_out_q;
  assign tx_pin_oe_n = ~tx_run;

  // The reserved select drives no interrupt rather than an undefined condition.
  assign tx_irq = (ctrl_q.tx_isel == `TXISEL_EMPTY) ? ~fifo_out_valid :
                  (ctrl_q.tx_isel == `TXISEL_DONE) ? tx_all_empty :
                  (ctrl_q.tx_isel == `TXISEL_FREE) ? ~tx_buffer_full : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Receiver.

  logic rx_s1_q;
  logic rx_s2_q;
  logic [3:0] rx_sub_q;
  logic [3:0] rx_bit_q;
  logic [7:0] rx_shift_q;

  wire rx_run = on_q & ctrl_q.rx_en;
  wire rx_sub_end = tick & (rx_sub_q == `SUB_LAST);
  wire char_done = (rx_state_q == uart_pkg::RX_STOP) & rx_sub_end;
  wire is_match = rx_shift_q == ctrl_q.match;
  wire accept = char_done & (~ctrl_q.auto_match | locked_q | is_match);
  assign rx_pin_owned = rx_run;
  assign rx_irq = avail_q;
  assign auto_match_active = ctrl_q.auto_match & on_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin_in;
      rx_s2_q <= rx_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_q <= uart_pkg::RX_IDLE;
      rx_sub_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_shift_q <= 8'h00;
    end else if (~rx_run) begin
      rx_state_q <= uart_pkg::RX_IDLE;
      rx_sub_q <= 4'h0;
    end else if (tick) begin
      rx_sub_q <= rx_sub_q + 4'h1;
      case (rx_state_q)
        uart_pkg::RX_IDLE: begin
          rx_sub_q <= 4'h0;
          if (~rx_s2_q) begin
            rx_state_q <= uart_pkg::RX_START;
          end
        end
        uart_pkg::RX_START: begin
          if (rx_sub_q == `SUB_MID) begin
            rx_sub_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_state_q <= rx_s2_q ? uart_pkg::RX_IDLE : uart_pkg::RX_BITS;
          end
        end
        uart_pkg::RX_BITS: begin
          if (rx_sub_end) begin
            rx_shift_q <= {rx_s2_q, rx_shift_q[7:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == `DATA_BITS - 4'h1) begin
              rx_state_q <= uart_pkg::RX_STOP;
            end
          end
        end
        uart_pkg::RX_STOP: begin
          if (rx_sub_end) begin
            rx_state_q <= uart_pkg::RX_IDLE;
          end
        end
        default: rx_state_q <= uart_pkg::RX_IDLE;
      endcase
    end
  end

  // The holding register is one deep, so a character that finds it full is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_q <= 8'h00;
      avail_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
      overrun_flag_q <= 1'b0;
      locked_q <= 1'b0;
    end else begin
      if (accept & (~avail_q | rxd_rd)) begin
        rx_data_q <= rx_shift_q;
        framing_error_flag_q <= ~rx_s2_q;
      end
      avail_q <= (accept & (~avail_q | rxd_rd)) | (avail_q & ~rxd_rd);
      overrun_flag_q <= (accept & avail_q & ~rxd_rd) | (overrun_flag_q & ~(sta_wr & ~pwdata[`STA_OVERRUN_FLAG]));
      locked_q <= ctrl_q.auto_match & (locked_q | (char_done & is_match));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_write_sta_read;
    psel & ~penable & ~pwrite & sel_sta;
  endsequence

  chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    s_write_sta_read |=> prdata[31:25] == 7'h00) else $error("reserved status bits not zero");
  chk_txbf_count: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q.tx_en |-> tx_buffer_full == !fifo_in_ready) else $error("full flag wrong");
  chk_tx_all_empty_idle: assert property (@(posedge pclk) disable iff (!presetn)
    tx_all_empty |-> (tx_idle && (fifo_count == '0 || !ctrl_q.tx_en))) else $error("empty flag while busy");
  chk_irq_empty: assert property (@(posedge pclk) disable iff (!presetn)
    ctrl_q.tx_isel == 2'b10 |-> tx_irq == (fifo_count == '0 || !ctrl_q.tx_en)) else $error("empty irq wrong");
  chk_irq_free: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.tx_isel == 2'b00 && ctrl_q.tx_en) |-> tx_irq == (fifo_count < CW'(TX_DEPTH)))
    else $error("free slot irq wrong");
  chk_irq_done: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q.tx_isel == 2'b01 && !tx_idle) |-> !tx_irq) else $error("done irq during frame");
  chk_disable_flush: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q.tx_en |-> tx_pin_oe_n ##1 (fifo_count == '0 && tx_idle)) else $error("disable not aborting");
  chk_idle_plain: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_idle && !ir_q) ##1 (tx_idle && !ir_q && $stable(ctrl_q.tx_inv)) |-> tx_pin_out == !ctrl_q.tx_inv)
    else $error("plain idle level wrong");
  chk_idle_ir: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_idle && ir_q) ##1 (tx_idle && ir_q && $stable(ctrl_q.tx_inv)) |-> tx_pin_out == ctrl_q.tx_inv)
    else $error("infrared idle level wrong");
  chk_break_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (brk_done && !sta_wr) |=> !brk_q) else $error("break request not cleared");
  chk_break_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_is_brk_q && tx_state_q == uart_pkg::TX_BITS) |-> !line_bit) else $error("break bit not zero");
  chk_rx_owned: assert property (@(posedge pclk) disable iff (!presetn)
    !rx_pin_owned |=> receiver_idle) else $error("receiver runs without pin");
  chk_overrun_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (overrun_flag_q && !(sta_wr && !pwdata[`STA_OVERRUN_FLAG])) |=> overrun_flag_q) else $error("overrun lost");
  chk_match_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (char_done && ctrl_q.auto_match && !locked_q && !is_match) |=> $stable(rx_data_q) && !$rose(avail_q))
    else $error("unmatched character accepted");
endmodule

// >>> verification/serial_node.sv
// Remote serial node: decodes the port's transmit line and sends frames to its receive line.
`timescale 1ns/1ns
module serial_node #(
  parameter int BIT_CYC = 16
) (
  input wire logic pclk,
  input wire logic listen,
  input wire logic line_in,
  output logic line_out
);
  logic [7:0] last_byte;
  int low_run;
  int last_low;
  initial begin
    line_out = 1'b1;
    last_byte = 8'h00;
    low_run = 0;
    last_low = 0;
  end
  ////////////////////////////////////////
  // Low time is measured so that a break frame can be timed exactly.
  always @(posedge pclk) begin
    if (listen && !line_in) begin
      low_run <= low_run + 1;
    end else if (low_run != 0) begin
      last_low <= low_run;
      low_run <= 0;
    end
  end
  // Frames are sampled at mid-bit, first bit lowest.
  initial begin
    forever begin
      @(posedge pclk);
      if (listen && !line_in) begin
        repeat (BIT_CYC / 2) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYC) @(posedge pclk);
          last_byte[i] = line_in;
        end
        repeat (BIT_CYC) @(posedge pclk);
      end
    end
  end
  ////////////////////////////////////////
  // The line rests high between frames, as an idle serial line does.
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_out <= fr[i];
      repeat (BIT_CYC) @(posedge pclk);
    end
    repeat (BIT_CYC) @(posedge pclk);
  endtask
endmodule

// >>> verification/tb_uart_status_control.sv
// Bench for the serial port status and control register, with a remote node on the line.
`timescale 1ns/1ns
`include "uart_defs.svh"
module tb_uart_status_control;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, listen, line;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rx_pin_in, rx_pin_owned, tx_pin_out, tx_pin_oe_n, tx_irq, rx_irq, auto_match_active;
  int err_total, comparisons;
  // A released transmit pin rests at its pull-up level.
  assign line = tx_pin_oe_n ? 1'b1 : tx_pin_out;
  uart_status_control u_uart_status_control (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pin_in(rx_pin_in), .rx_pin_owned(rx_pin_owned),
    .tx_pin_out(tx_pin_out), .tx_pin_oe_n(tx_pin_oe_n), .tx_irq(tx_irq), .rx_irq(rx_irq),
    .auto_match_active(auto_match_active));
  serial_node node (.pclk(pclk), .listen(listen), .line_in(line), .line_out(rx_pin_in));
  ////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic check1(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd & m, exp);
  endtask
  task automatic wait_bit(input int b, input logic v);
    int i;
    i = 0;
    do begin
      apb(1'b0, `STA_OFFSET, 32'h0);
      i++;
    end while (rd[b] !== v && i < 500);
    check1(rd[b], v);
  endtask
  function automatic logic [31:0] sta(input logic am, input logic [7:0] m, input logic [1:0] s, input logic inv,
    input logic rxe, input logic brk, input logic txe);
    return {7'h00, am, m, s, inv, rxe, brk, txe, 10'h000};
  endfunction
  task automatic close_out;
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    #1000000;
    err_total++;
    close_out;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    listen = 1'b0;
    err_total = 0;
    comparisons = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdm(`STA_OFFSET, 32'hffffffff, 32'h00000110);
    check1(tx_pin_oe_n, 1'b1);
    check1(rx_pin_owned, 1'b0);
    check1(tx_irq, 1'b1);
    rdm(12'h014, 32'hffffffff, 32'h0);
    check1(er, 1'b1);
    wr(`STA_OFFSET, 32'hffff7400);
    rdm(`STA_OFFSET, 32'hffffffff, 32'h01ff7510);
    check1(auto_match_active, 1'b0);
    wr(`MODE_OFFSET, 32'h00008000);
    check1(auto_match_active, 1'b1);
    check1(rx_pin_owned, 1'b1);
    check1(tx_pin_oe_n, 1'b0);
    for (int k = 0; k < 4; k++) begin
      wr(`MODE_OFFSET, {16'h0, 1'b1, 2'h0, k[1], 12'h000});
      wr(`STA_OFFSET, sta(1'b0, 8'h00, 2'h0, k[0], 1'b1, 1'b0, 1'b1));
      repeat (3) @(posedge pclk);
      check1(tx_pin_out, k[1] ? k[0] : ~k[0]);
    end
    wr(`MODE_OFFSET, 32'h00008000);
    wr(`STA_OFFSET, sta(1'b0, 8'h00, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1));
    listen <= 1'b1;
    wr(`TXD_OFFSET, 32'h0000005a);
    rdm(`STA_OFFSET, 32'h00000100, 32'h0);
    wait_bit(8, 1'b1);
    check({24'h0, node.last_byte}, 32'h0000005a);
    wr(`STA_OFFSET, sta(1'b0, 8'h00, 2'h0, 1'b0, 1'b1, 1'b1, 1'b1));
    wait_bit(11, 1'b0);
    repeat (20) @(posedge pclk);
    check(32'(node.last_low), 32'd208);
    listen <= 1'b0;
    wr(`STA_OFFSET, sta(1'b1, 8'h3c, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1));
    node.send_byte(8'h11);
    check1(rx_irq, 1'b0);
    node.send_byte(8'h3c);
    check1(rx_irq, 1'b1);
    rdm(`RXD_OFFSET, 32'h000000ff, 32'h0000003c);
    node.send_byte(8'h22);
    node.send_byte(8'h33);
    rdm(`STA_OFFSET, 32'h00000003, 32'h00000003);
    rdm(`RXD_OFFSET, 32'h000000ff, 32'h00000022);
    wr(`STA_OFFSET, sta(1'b1, 8'h3c, 2'h0, 1'b0, 1'b1, 1'b0, 1'b1));
    rdm(`STA_OFFSET, 32'h00000002, 32'h0);
    wr(`STA_OFFSET, sta(1'b0, 8'h00, 2'h0, 1'b0, 1'b0, 1'b0, 1'b1));
    check1(auto_match_active, 1'b0);
    check1(rx_pin_owned, 1'b0);
    node.send_byte(8'h44);
    check1(rx_irq, 1'b0);
    // A slow line keeps the buffer from draining while it is filled.
    wr(`BAUD_OFFSET, 32'h000003e7);
    wr(`TXD_OFFSET, 32'h000000a1);
    wr(`TXD_OFFSET, 32'h000000a2);
    // Encoding 11 is reserved and never written.
    for (int i = 0; i < 3; i++) begin
      wr(`STA_OFFSET, sta(1'b0, 8'h00, i[1:0], 1'b0, 1'b1, 1'b0, 1'b1));
      check1(tx_irq, i == 0);
    end
    rdm(`STA_OFFSET, 32'h00000300, 32'h0);
    repeat (`TX_DEPTH) wr(`TXD_OFFSET, 32'h000000b0);
    rdm(`STA_OFFSET, 32'h00000300, 32'h00000200);
    for (int i = 0; i < 3; i++) begin
      wr(`STA_OFFSET, sta(1'b0, 8'h00, i[1:0], 1'b0, 1'b1, 1'b0, 1'b1));
      check1(tx_irq, 1'b0);
    end
    wr(`STA_OFFSET, sta(1'b0, 8'h00, 2'h2, 1'b0, 1'b1, 1'b0, 1'b0));
    check1(tx_pin_oe_n, 1'b1);
    rdm(`STA_OFFSET, 32'h00000300, 32'h00000100);
    check1(tx_irq, 1'b1);
    close_out;
  end
endmodule
